// ==== design/wdt_pkg.sv ====
// Constants shared by the watchdog timeout counter and its bench.
// Assumes a single crystal-derived clock and a plain strobe register port.
package wdt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] WD_SVC_ADDR = 16'hFFFF;
  localparam logic [15:0] CAUSE_ADDR = 16'hFE01;
  localparam logic [15:0] COUNT_ADDR = 16'hFE02;
  localparam int CAUSE_WD_BIT = 0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ----------------------------------------------------------------
  // Counter structure
  // ----------------------------------------------------------------
  localparam int PRESC_W = 12;
  localparam int CNT_W = 6;
  localparam int SVC_CLR_LSB = 4;
  localparam logic [5:0] SHORT_LIMIT = 6'h01;
  localparam logic [5:0] LONG_LIMIT = 6'h3F;
  // Overflow tap sits 2^4 counts short of the prescaler wrap
  localparam logic [11:0] OVF_TAP = 12'hFEF;

  // ----------------------------------------------------------------
  // Reset pulse timing, in crystal clock cycles
  // ----------------------------------------------------------------
  localparam int RST_PULSE_CYC = 32;
  localparam logic [4:0] PULSE_LAST = 5'h1F;

  typedef enum logic [0:0] {
    WDT_IDLE = 1'b0,
    WDT_PULSE = 1'b1
  } wdt_state_t;

endpackage : wdt_pkg

// ==== design/wdt_top.sv ====
// Watchdog timeout counter: prescaler, 6-bit watchdog stage, reset pulse.
// Assumes i_clk is the crystal oscillator clock and inputs are synchronous.
//
// Behaviour
// R1: 12-bit prescaler advances a free-running 6-bit counter; overflow from 6-bit stage.
// R2: All timing runs from the crystal clock only, never the synthesizer clock.
// R3: Overflow resets after 2^13-2^4 or 2^18-2^4 cycles, chosen by short-timeout bit.
// R4: Any write to service location clears counter and prescaler bits 11 to 4.
// R5: Read of service location returns reset vector low byte.
// R6: Watchdog reset drives reset pin low 32 cycles and sets cause flag.
// R7: Internal reset clears prescaler and watchdog counter.
// R8: Executed stop instruction clears the prescaler.
// R9: Reset vector fetch clears the prescaler.
// R10: Reset inhibit option suppresses all watchdog resets.
// R11: Monitor mode with elevated voltage on reset or interrupt pin disables watchdog.
// R12: Break with elevated voltage on reset pin disables watchdog.
// R13: Watchdog raises no interrupt request; reset is its only action.
// R14: Counting continues through wait mode.
// R15: Stop mode freezes the count and clears the prescaler.
// R16: Stop instruction is not allowed while halt-allow option is zero.
// R17: Software services before entering and after leaving stop mode.
// R18: Software services from main flow, not only from interrupts.
// R19: Option bits are static inputs sampled continuously.
// R20: Service write in the overflow cycle wins; no reset issued.
`timescale 1ns/1ps
module wdt_top #(
  parameter logic [7:0] RST_VEC_LO = 8'h00  // Arbitrary default, tie to the real vector
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [wdt_pkg::ADDR_W-1:0] i_addr,
  input wire logic [wdt_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [wdt_pkg::DATA_W-1:0] o_rdata,
  // Option bits
  input wire logic i_short_timeout_select,
  input wire logic i_watchdog_reset_inhibit,
  input wire logic i_halt_allow,
  // System events
  input wire logic i_int_reset,
  input wire logic i_stop_exec,
  input wire logic i_stop_mode,
  input wire logic i_vec_fetch,
  input wire logic i_wait_mode,
  // Test modes
  input wire logic i_monitor_mode,
  input wire logic i_break_active,
  input wire logic i_rst_pin_hv,
  input wire logic i_irq_pin_hv,
  // Reset pin (open drain) and status
  output logic o_rst_pin_o,
  output logic o_rst_pin_oe,
  output logic o_wd_reset,
  output logic o_cause_wd,
  output logic o_stop_enable
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdt_state_t state_ff, nxt_state;
  logic [PRESC_W-1:0] presc_ff, nxt_presc;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [4:0] pulse_ff, nxt_pulse;
  logic cause_ff, nxt_cause;
  logic oe_ff, nxt_oe;
  logic stop_en_ff, nxt_stop_en;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic pin_o_ff, nxt_pin_o;

  logic svc_wr;
  logic stop_ok;
  logic frozen;
  logic wd_disabled;
  logic at_limit;
  logic overflow;
  logic fire;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  // ----------------------------------------------------------------
  // Decode and conditions
  // ----------------------------------------------------------------
  always_comb begin
    svc_wr = i_wr && hit(i_addr, WD_SVC_ADDR);
    // Stop only counts when the halt-allow option permits it
    stop_ok = i_halt_allow;  // R16 R19
    frozen = i_stop_mode && stop_ok;  // R15
    wd_disabled = i_watchdog_reset_inhibit  // R10 R19
      || (i_monitor_mode && (i_rst_pin_hv || i_irq_pin_hv))  // R11
      || (i_break_active && i_rst_pin_hv);  // R12
    at_limit = i_short_timeout_select ? (cnt_ff == SHORT_LIMIT) : (cnt_ff == LONG_LIMIT);  // R3
    // Early tap trims the last period, so a timeout is 2^4 short of a full power of two
    overflow = (presc_ff == OVF_TAP) && at_limit && !frozen;  // R1 R3
    // Service in the same cycle beats the overflow
    fire = overflow && !svc_wr && !wd_disabled && (state_ff == WDT_IDLE);  // R20
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Wait mode deliberately has no term here: counting goes on.
  always_comb begin
    nxt_presc = presc_ff;
    nxt_cnt = cnt_ff;
    if (i_int_reset || state_ff == WDT_PULSE) begin
      nxt_presc = '0;  // R7
      nxt_cnt = '0;  // R7
    end else begin
      if (frozen) begin
        nxt_presc = presc_ff;  // R15
      end else begin
        nxt_presc = presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};  // R2 R14
        if (&presc_ff) begin
          nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};  // R1
        end
      end
      if (svc_wr) begin
        nxt_presc[PRESC_W-1:SVC_CLR_LSB] = '0;  // R4
        nxt_cnt = '0;  // R4
      end
      if ((i_stop_exec && stop_ok) || i_vec_fetch || frozen) begin
        nxt_presc = '0;  // R8 R9 R15
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset pulse sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_pulse = pulse_ff;
    nxt_oe = oe_ff;
    unique case (state_ff)
      WDT_IDLE: begin
        if (fire) begin
          nxt_state = WDT_PULSE;
          nxt_pulse = '0;
          nxt_oe = 1'b1;  // R6
        end
      end
      WDT_PULSE: begin
        nxt_pulse = pulse_ff + 5'h01;
        if (pulse_ff == PULSE_LAST) begin
          nxt_state = WDT_IDLE;
          nxt_oe = 1'b0;  // R6
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register port and cause flag
  // ----------------------------------------------------------------
  // Only a reset action exists; no interrupt output is provided.
  always_comb begin
    nxt_cause = cause_ff;
    if (i_wr && hit(i_addr, CAUSE_ADDR)) begin
      nxt_cause = 1'b0;
    end
    // A clearing write in the fire cycle loses: the set wins
    if (fire) begin
      nxt_cause = 1'b1;  // R6 R13
    end
    nxt_stop_en = i_halt_allow;  // R16
    nxt_pin_o = 1'b0;
    nxt_rdata = UNMAPPED_RD;
    if (i_rd) begin
      if (hit(i_addr, WD_SVC_ADDR)) begin
        nxt_rdata = RST_VEC_LO;  // R5
      end else if (hit(i_addr, CAUSE_ADDR)) begin
        nxt_rdata = {7'h00, cause_ff};
      end else if (hit(i_addr, COUNT_ADDR)) begin
        nxt_rdata = {2'h0, cnt_ff};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= WDT_IDLE;
      presc_ff <= '0;
      cnt_ff <= '0;
      pulse_ff <= 5'h00;
      cause_ff <= 1'b0;
      oe_ff <= 1'b0;
      stop_en_ff <= 1'b0;
      rdata_ff <= RDATA_RST;
      pin_o_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      presc_ff <= nxt_presc;
      cnt_ff <= nxt_cnt;
      pulse_ff <= nxt_pulse;
      cause_ff <= nxt_cause;
      oe_ff <= nxt_oe;
      stop_en_ff <= nxt_stop_en;
      rdata_ff <= nxt_rdata;
      pin_o_ff <= nxt_pin_o;
    end
  end

  // Pin data is always low; the enable alone pulls the line.
  assign o_rst_pin_o = pin_o_ff;
  assign o_rst_pin_oe = oe_ff;
  assign o_wd_reset = oe_ff;
  assign o_cause_wd = cause_ff;
  assign o_stop_enable = stop_en_ff;
  assign o_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SVC_CLEARS: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R4
    (svc_wr && !frozen) |=> (cnt_ff == '0) && (presc_ff[PRESC_W-1:SVC_CLR_LSB] == '0))
    else $error("service write did not clear counter");
  AST_READ_VEC: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R5
    (i_rd && i_addr == WD_SVC_ADDR) |=> (o_rdata == RST_VEC_LO))
    else $error("service location read not reset vector");
  AST_PULSE_LEN: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R6
    $rose(o_rst_pin_oe) |-> ##31 o_rst_pin_oe ##1 !o_rst_pin_oe)
    else $error("reset pulse not 32 cycles");
  AST_CAUSE_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R6
    $rose(o_rst_pin_oe) |-> o_cause_wd)
    else $error("cause flag not set with reset");
  AST_OVF_FIRES: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R3
    (overflow && !svc_wr && !wd_disabled && !o_rst_pin_oe) |=> $rose(o_rst_pin_oe))
    else $error("overflow did not reset");
  AST_INHIBIT: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R10
    (i_watchdog_reset_inhibit && !o_rst_pin_oe) |=> !o_rst_pin_oe)
    else $error("reset despite inhibit");
  AST_MON_DIS: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R11
    (i_monitor_mode && (i_rst_pin_hv || i_irq_pin_hv) && !o_rst_pin_oe) |=> !o_rst_pin_oe)
    else $error("reset in monitor mode with high voltage");
  AST_BRK_DIS: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R12
    (i_break_active && i_rst_pin_hv && !o_rst_pin_oe) |=> !o_rst_pin_oe)
    else $error("reset in break with high voltage");
  AST_INT_RST: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R7
    i_int_reset |=> (presc_ff == '0) && (cnt_ff == '0))
    else $error("internal reset did not clear counters");
  AST_STOP_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R8
    ((i_stop_exec && i_halt_allow) || i_vec_fetch) |=> (presc_ff == '0))  // R9
    else $error("prescaler not cleared");
  AST_FREEZE: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R15
    (frozen && !svc_wr && !i_int_reset && !o_rst_pin_oe) |=> $stable(cnt_ff))
    else $error("count moved in stop mode");
  AST_PRIO: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R20
    (svc_wr && !o_rst_pin_oe) |=> !o_rst_pin_oe)
    else $error("reset despite service write");
  AST_WAIT_RUN: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R14
    (i_wait_mode && !frozen && !i_int_reset && !svc_wr && !i_vec_fetch && !i_stop_exec
      && !o_rst_pin_oe) |=> (presc_ff == $past(presc_ff) + 12'h001))
    else $error("prescaler stalled in wait mode");

  // ----------------------------------------------------------------
  // Checks on counter steps, pulse and register port
  // ----------------------------------------------------------------
  // Antecedents leave out every clearing event so each property sees one rule.
  localparam logic [PRESC_W-1:0] LOW_MASK =
    {{(PRESC_W-SVC_CLR_LSB){1'b0}}, {SVC_CLR_LSB{1'b1}}};
  AST_CNT_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R1
    (presc_ff != '1 && !i_int_reset && !svc_wr && !o_rst_pin_oe) |=> $stable(cnt_ff))
    else $error("watchdog counter moved between prescaler wraps");
  AST_CNT_STEP: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R1
    ((&presc_ff) && !frozen && !i_int_reset && !svc_wr && !o_rst_pin_oe)
      |=> (cnt_ff == $past(cnt_ff) + 6'h01))
    else $error("watchdog counter missed a prescaler wrap");
  AST_ONLY_OVF: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R3
    $rose(o_rst_pin_oe) |-> $past(overflow))
    else $error("reset pulse without overflow");
  AST_SVC_LOW: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R4
    (svc_wr && !frozen && !i_int_reset && !i_vec_fetch && !i_stop_exec && !o_rst_pin_oe)
      |=> ((presc_ff & LOW_MASK) == (($past(presc_ff) + 12'h001) & LOW_MASK)))
    else $error("service write disturbed low prescaler bits");
  AST_RD_IDLE: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R5
    !i_rd |=> (o_rdata == UNMAPPED_RD))
    else $error("read data did not return to idle");
  AST_PULSE_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R6
    o_rst_pin_oe |=> (presc_ff == '0) && (cnt_ff == '0))
    else $error("counters ran during reset pulse");
  AST_CAUSE_KEEP: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R6
    (o_cause_wd && !(i_wr && i_addr == CAUSE_ADDR)) |=> o_cause_wd)
    else $error("cause flag lost without a clearing write");
  AST_VEC_CNT: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R9
    (i_vec_fetch && presc_ff != '1 && !i_int_reset && !svc_wr && !o_rst_pin_oe) |=> $stable(cnt_ff))
    else $error("vector fetch touched the watchdog counter");
  AST_STOP_IGN: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R16
    (i_stop_exec && !i_halt_allow && !i_int_reset && !svc_wr && !i_vec_fetch
      && !o_rst_pin_oe) |=> (presc_ff == $past(presc_ff) + 12'h001))
    else $error("disallowed stop cleared the prescaler");
  AST_STOP_EN: assert property (@(posedge i_clk) disable iff (!i_resetn)  // R16 R19
    1'b1 |=> (o_stop_enable == $past(i_halt_allow)))
    else $error("stop enable does not follow halt allow");

endmodule : wdt_top

// ==== test/wdt_tb.sv ====
// Self-checking bench for the watchdog timeout counter, short mode plus one long-mode count.
// Assumes the bench alone drives every port; no far-side model.
`timescale 1ns/1ps
module tb;
  import wdt_pkg::*;
  logic i_clk, i_resetn, i_wr, i_rd, i_sts, i_inh, i_halt, i_ires, i_sexe, i_smode;
  logic i_vf, i_wait, i_mon, i_brk, i_rhv, i_qhv, oe, wdr, pin, cause, sten;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, rdata;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  logic [4:0] cfg [4] = '{5'h10, 5'h0A, 5'h09, 5'h06};
  wdt_top #(.RST_VEC_LO(8'hA5)) DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_short_timeout_select(i_sts), .i_watchdog_reset_inhibit(i_inh), .i_halt_allow(i_halt),
    .i_int_reset(i_ires), .i_stop_exec(i_sexe), .i_stop_mode(i_smode), .i_vec_fetch(i_vf),
    .i_wait_mode(i_wait), .i_monitor_mode(i_mon), .i_break_active(i_brk),
    .i_rst_pin_hv(i_rhv), .i_irq_pin_hv(i_qhv), .o_rst_pin_o(pin), .o_rst_pin_oe(oe),
    .o_wd_reset(wdr), .o_cause_wd(cause), .o_stop_enable(sten));
  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 105000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= 8'h3C;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge i_clk);
    case (k)
      0: i_ires <= 1'b1;
      1: i_sexe <= 1'b1;
      default: i_vf <= 1'b1;
    endcase
    @(posedge i_clk);
    {i_ires, i_sexe, i_vf} <= 3'h0;
  endtask : pulse
  // Edges until the reset pin is pulled, capped at lim
  task automatic wait_rst(input int lim);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      #1;
    end while (oe !== 1'b1 && n < lim);
  endtask : wait_rst
  task automatic no_rst(input int len);
    logic seen;
    seen = 1'b0;
    repeat (len) begin
      @(posedge i_clk);
      #1 seen = seen | (oe !== 1'b0);
    end
    chk({7'h00, seen}, 8'h00);
  endtask : no_rst
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_timeout();
    wait_rst(9000);
    chk(n[15:8], 8'h1F);
    chk(n[7:0], 8'hF0);
    chk({wdr, pin, cause}, 8'h05);
    n = 1;
    while (oe === 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1 if (oe === 1'b1) n++;
    end
    chk(n[7:0], 8'h20);
    rd(CAUSE_ADDR, 8'h01);
    wr(CAUSE_ADDR);
    rd(CAUSE_ADDR, 8'h00);
    rd(16'hFE00, 8'h00);
  endtask : s_timeout
  task automatic s_service();
    rd(WD_SVC_ADDR, 8'hA5);
    repeat (3) begin
      wr(WD_SVC_ADDR);
      rd(COUNT_ADDR, 8'h00);
      no_rst(3000);
    end
  endtask : s_service
  task automatic s_events();
    for (int k = 0; k < 3; k++) begin
      wr(WD_SVC_ADDR);
      no_rst(3900);
      pulse(k);
      no_rst(4300);
    end
  endtask : s_events
  task automatic s_disable();
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      {i_inh, i_mon, i_brk, i_rhv, i_qhv} <= cfg[k];
      pulse(0);
      no_rst(8250);
    end
    @(posedge i_clk);
    {i_inh, i_mon, i_brk, i_rhv, i_qhv} <= 5'h00;
  endtask : s_disable
  task automatic s_stop();
    pulse(0);
    wr(WD_SVC_ADDR);
    @(posedge i_clk);
    i_smode <= 1'b1;
    no_rst(8300);
    chk({7'h00, sten}, 8'h01);
    @(posedge i_clk);
    i_halt <= 1'b0;
    pulse(0);
    no_rst(4000);
    // Disallowed stop must not restart the period
    pulse(1);
    wait_rst(4300);
    chk({7'h00, oe}, 8'h01);
    chk({7'h00, sten}, 8'h00);
    repeat (33) @(posedge i_clk);
    i_smode <= 1'b0;
    wr(WD_SVC_ADDR);
  endtask : s_stop
  task automatic s_long();
    @(posedge i_clk);
    i_sts <= 1'b0;
    pulse(0);
    no_rst(8250);
    rd(COUNT_ADDR, 8'h02);
    @(posedge i_clk);
    i_sts <= 1'b1;
  endtask : s_long
  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    {i_resetn, i_wr, i_rd, i_inh, i_ires, i_sexe, i_smode, i_vf} = 8'h00;
    {i_mon, i_brk, i_rhv, i_qhv, i_sts, i_halt, i_wait} = 7'h07;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    s_timeout();
    s_service();
    s_events();
    s_disable();
    s_stop();
    s_long();
    print_verdict();
  end
endmodule : tb
